// >>> src/tfc_trace_fifo_capture.v
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tfc_map.vh"
module tfc_trace_fifo_capture #(
    parameter DEPTH = 8,
    parameter AW    = 17
) (
    input  wire          core_clk_in,
    input  wire          rst_b_in,
    input  wire          clk_en_in,
    input  wire          sys_reset_in,
    input  wire [AW-1:0] core_addr_in,
    input  wire [AW-1:0] opcode_addr_in,
    input  wire [7:0]    core_data_in,
    input  wire [1:0]    core_cof_in,
    input  wire          irq_pending_in,
    input  wire          match_a_in,
    input  wire          match_b_in,
    input  wire          trig_addr_in,
    input  wire          trig_opcode_in,
    input  wire [3:0]    trig_mode_in,
    input  wire          psel_in,
    input  wire          penable_in,
    input  wire          pwrite_in,
    input  wire [11:0]   paddr_in,
    input  wire [31:0]   pwdata_in,
    output reg  [31:0]   prdata_out,
    output reg           pready_out,
    output reg           pslverr_out,
    output reg           break_req_out,
    output reg  [7:0]    comp_a_ext_out,
    output reg  [7:0]    comp_a_high_out,
    output reg  [7:0]    comp_a_low_out
);
    // ==========================================
    // State
    reg [AW-1:0] fifo_mem [0:DEPTH-1];
    reg [3:0]    valid_word_count_reg;
    reg [7:0]    debug_control_reg;
    reg [7:0]    trigger_config_reg;
    reg          armed_flag_reg;
    reg          match_a_flag_reg;
    reg          match_b_flag_reg;
    reg          match_c_flag_reg;
    reg [AW-1:0] prev_addr_reg;
    reg [AW-1:0] profile_reg;
    reg          triggered_reg;
    reg [3:0]    unread_reg;
    integer      i;
    localparam [AW-1:0] BR_DEC = `TFC_COF_DEC;

    wire unit_enable  = debug_control_reg[`TFC_C_EN];
    wire arm_bit      = debug_control_reg[`TFC_C_ARM];
    wire break_enable = debug_control_reg[`TFC_C_BRK];
    wire opcode_trigger_select = trigger_config_reg[`TFC_T_OPSEL];
    wire event_mode = (trig_mode_in == `TFC_MODE_EVB) || (trig_mode_in == `TFC_MODE_AEVB);
    // Event modes are begin type whatever the begin bit says, except at system reset, which reads the bit alone
    wire begin_mode = trigger_config_reg[`TFC_T_BEGIN] | event_mode;
    wire armed      = unit_enable & arm_bit & armed_flag_reg;
    // Unread trace words are served first; once drained, reads of an enabled, disarmed unit show the profile sample
    wire use_fifo   = armed | ~unit_enable | (unread_reg != 4'h0);

    // Opcode triggers lose to a coincident interrupt; address triggers do not
    wire trig_hit = opcode_trigger_select ? (trig_opcode_in & ~irq_pending_in)
                                          : trig_addr_in;

    // ==========================================
    // Bus decode
    wire acc    = psel_in & penable_in & pready_out;
    wire wr_acc = acc & pwrite_in;
    wire rd_acc = acc & ~pwrite_in;
    wire known  = (paddr_in[1:0] == 2'b00) && (paddr_in <= `TFC_OFF_CMPA_LO);
    wire rd_low = rd_acc & (paddr_in == `TFC_OFF_DLOW);
    wire wr_ctl = wr_acc & (paddr_in == `TFC_OFF_CTRL);

    // Capture entry selection
    wire [AW-1:0] br_src = prev_addr_reg - BR_DEC;
    wire          cof_any = |core_cof_in;
    wire [AW-1:0] cof_word = core_cof_in[1] ? core_addr_in : br_src;
    wire [AW-1:0] ev_word  = {{(AW-8){1'b0}}, core_data_in};
    wire          begin_go = begin_mode & (triggered_reg | trig_hit);
    // The trigger flow change is kept; disarming stops the later vector flow change
    wire          end_hit  = ~begin_mode & trig_hit;
    wire          store_cof = armed & cof_any & ~event_mode &
                              (begin_go | ~begin_mode);
    wire          store_ev  = armed & event_mode & begin_go & match_b_in;
    wire          do_store  = (store_cof | store_ev) & ~(rd_low & armed);
    wire [AW-1:0] new_word  = event_mode ? ev_word : cof_word;
    wire          full      = (valid_word_count_reg == DEPTH[3:0]);

    function [31:0] rd_mux;
        input [11:0] a;
        begin
            case (a)
                `TFC_OFF_CTRL:   rd_mux = {24'h00_0000, debug_control_reg};
                `TFC_OFF_STATUS: rd_mux = {24'h00_0000, match_a_flag_reg, match_b_flag_reg,
                                           match_c_flag_reg, 4'h0, armed_flag_reg};
                `TFC_OFF_TRIG:   rd_mux = {24'h00_0000, trigger_config_reg};
                `TFC_OFF_COUNT:  rd_mux = {28'h000_0000, valid_word_count_reg};
                `TFC_OFF_DHIGH:  rd_mux = use_fifo ? {23'h00_0000, fifo_mem[0][AW-1:8]}
                                        : {23'h00_0000, profile_reg[AW-1:8]};
                `TFC_OFF_DLOW:   rd_mux = {24'h00_0000, use_fifo ? fifo_mem[0][7:0]
                                                                 : profile_reg[7:0]};
                `TFC_OFF_CMPA_EXT: rd_mux = {24'h00_0000, comp_a_ext_out};
                `TFC_OFF_CMPA_HI:  rd_mux = {24'h00_0000, comp_a_high_out};
                `TFC_OFF_CMPA_LO:  rd_mux = {24'h00_0000, comp_a_low_out};
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // ==========================================
    // Main process; the unit has no reset output at all
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            debug_control_reg    <= `TFC_RST_CTRL;
            trigger_config_reg   <= `TFC_RST_TRIG;
            comp_a_ext_out       <= `TFC_RST_CAX;
            comp_a_high_out      <= `TFC_RST_CAH;
            comp_a_low_out       <= `TFC_RST_CAL;
            armed_flag_reg       <= 1'b1;
            match_a_flag_reg     <= 1'b0;
            match_b_flag_reg     <= 1'b0;
            match_c_flag_reg     <= 1'b0;
            valid_word_count_reg <= 4'h0;
            unread_reg           <= 4'h0;
            triggered_reg        <= 1'b0;
            prev_addr_reg        <= {AW{1'b0}};
            profile_reg          <= {AW{1'b0}};
            prdata_out           <= 32'h0000_0000;
            pready_out           <= 1'b0;
            pslverr_out          <= 1'b0;
            break_req_out        <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1)
                fifo_mem[i] <= {AW{1'b0}};
        end else if (clk_en_in) begin
            pready_out    <= psel_in & ~pready_out;
            pslverr_out   <= psel_in & ~pready_out & ~known;
            prdata_out    <= (psel_in & ~pwrite_in & known) ? rd_mux(paddr_in) : 32'h0000_0000;
            prev_addr_reg <= core_addr_in;
            break_req_out <= 1'b0;
            if (sys_reset_in) begin
                // Reset while an end run is set up keeps the trace for readout
                if (unit_enable & ~trigger_config_reg[`TFC_T_BEGIN]) begin
                    debug_control_reg[`TFC_C_ARM] <= 1'b0;
                    debug_control_reg[`TFC_C_BRK] <= 1'b0;
                    armed_flag_reg                <= 1'b0;
                end else begin
                    debug_control_reg  <= `TFC_RST_CTRL;
                    trigger_config_reg <= `TFC_RST_TRIG;
                    comp_a_ext_out     <= `TFC_RST_CAX;
                    comp_a_high_out    <= `TFC_RST_CAH;
                    comp_a_low_out     <= `TFC_RST_CAL;
                    armed_flag_reg     <= 1'b1;
                    match_a_flag_reg   <= 1'b0;
                    match_b_flag_reg   <= 1'b0;
                    match_c_flag_reg   <= 1'b0;
                    valid_word_count_reg <= 4'h0;
                    unread_reg         <= 4'h0;
                    triggered_reg      <= 1'b0;
                end
            end else begin
                // Match flags; on an arm in the same cycle the A and B sets win and C is cleared
                if (wr_ctl & pwdata_in[`TFC_C_ARM] & pwdata_in[`TFC_C_EN]) begin
                    armed_flag_reg       <= 1'b1;
                    valid_word_count_reg <= 4'h0;
                    unread_reg           <= 4'h0;
                    triggered_reg        <= 1'b0;
                    match_a_flag_reg     <= match_a_in;
                    match_b_flag_reg     <= match_b_in;
                    match_c_flag_reg     <= 1'b0;
                end else begin
                    if (match_a_in & armed)
                        match_a_flag_reg <= 1'b1;
                    if (match_b_in & armed)
                        match_b_flag_reg <= 1'b1;
                    if (armed & trig_hit)
                        match_c_flag_reg <= 1'b1;
                end
                if (wr_ctl)
                    debug_control_reg <= pwdata_in[7:0];
                if (wr_acc & (paddr_in == `TFC_OFF_TRIG))
                    trigger_config_reg <= pwdata_in[7:0];
                if (wr_acc & (paddr_in == `TFC_OFF_CMPA_EXT))
                    comp_a_ext_out <= pwdata_in[7:0];
                if (wr_acc & (paddr_in == `TFC_OFF_CMPA_HI))
                    comp_a_high_out <= pwdata_in[7:0];
                if (wr_acc & (paddr_in == `TFC_OFF_CMPA_LO))
                    comp_a_low_out <= pwdata_in[7:0];
                if ((wr_ctl & ~pwdata_in[`TFC_C_ARM]) | ~unit_enable)
                    armed_flag_reg <= 1'b0;
                // Trigger latch for begin runs
                if (armed & begin_mode & trig_hit)
                    triggered_reg <= 1'b1;
                // Buffer store: shift in at the tail, oldest falls out when full
                if (do_store) begin
                    if (full) begin
                        for (i = 0; i < DEPTH - 1; i = i + 1)
                            fifo_mem[i] <= fifo_mem[i+1];
                        fifo_mem[DEPTH-1] <= new_word;
                    end else begin
                        fifo_mem[valid_word_count_reg[2:0]] <= new_word;
                        valid_word_count_reg <= valid_word_count_reg + 4'h1;
                        unread_reg           <= unread_reg + 4'h1;
                    end
                end
                // Begin run disarms once the buffer fills
                if (armed & begin_mode & do_store &
                    (valid_word_count_reg == DEPTH[3:0] - 4'h1)) begin
                    debug_control_reg[`TFC_C_ARM] <= 1'b0;
                    armed_flag_reg                <= 1'b0;
                    break_req_out                 <= break_enable;
                end
                // End run stops on the trigger
                if (armed & end_hit) begin
                    debug_control_reg[`TFC_C_ARM] <= 1'b0;
                    armed_flag_reg                <= 1'b0;
                    break_req_out                 <= break_enable;
                end
                // Low read: shift when idle, sample opcode address for profiling
                if (rd_low & ~armed & unit_enable) begin
                    for (i = 0; i < DEPTH - 1; i = i + 1)
                        fifo_mem[i] <= fifo_mem[i+1];
                    fifo_mem[DEPTH-1] <= {AW{1'b0}};
                    if (unread_reg != 4'h0)
                        unread_reg <= unread_reg - 4'h1;
                    profile_reg <= opcode_addr_in;
                end
            end
        end
    end
endmodule

// >>> src/tfc_map.vh
`ifndef TFC_MAP_VH
`define TFC_MAP_VH
// ==========================================
// Register byte offsets
`define TFC_OFF_CTRL     12'h000
`define TFC_OFF_STATUS   12'h004
`define TFC_OFF_TRIG     12'h008
`define TFC_OFF_COUNT    12'h00C
`define TFC_OFF_DHIGH    12'h010
`define TFC_OFF_DLOW     12'h014
`define TFC_OFF_CMPA_EXT 12'h018
`define TFC_OFF_CMPA_HI  12'h01C
`define TFC_OFF_CMPA_LO  12'h020
// ==========================================
// Control fields
`define TFC_C_EN         7
`define TFC_C_ARM        6
`define TFC_C_BRK        5
// Status fields
`define TFC_S_MATCH_A    7
`define TFC_S_MATCH_B    6
`define TFC_S_MATCH_C    5
`define TFC_S_ARMED      0
// Trigger fields
`define TFC_T_OPSEL      7
`define TFC_T_BEGIN      6
// ==========================================
// Reset values
`define TFC_RST_CTRL     8'hC0
`define TFC_RST_TRIG     8'h40
`define TFC_RST_CAX      8'h00
`define TFC_RST_CAH      8'hFF
`define TFC_RST_CAL      8'hFE
// Mode codes of the trig_mode_in input, then the branch source decrement
`define TFC_MODE_EVB     4'h3
`define TFC_MODE_AEVB    4'h4
`define TFC_COF_DEC      17'h0_0002
`endif

// >>> verification/tfc_props.sv
`timescale 1ns/1ps
// ==========================================
// Bus, break pulse and reset checks
module tfc_props (
    input wire        core_clk_in,
    input wire        rst_b_in,
    input wire        clk_en_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        break_req_out,
    input wire [7:0]  comp_a_ext_out,
    input wire [7:0]  comp_a_high_out,
    input wire [7:0]  comp_a_low_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_setup;
        psel_in && !penable_in && clk_en_in;
    endsequence
    sequence s_answer;
        pready_out ##1 !pready_out;
    endsequence
    chk_ready_next: assert property (s_setup |=> s_answer)
        else $error("ready not one cycle after setup");
    chk_ready_cause: assert property (pready_out |-> $past(psel_in) && !$past(penable_in))
        else $error("ready without setup");
    chk_ready_idle: assert property (!psel_in |=> !pready_out)
        else $error("ready while idle");
    chk_err_zero: assert property (pslverr_out |-> prdata_out == 32'h0000_0000)
        else $error("refused read with data");
    chk_err_ready: assert property (!pready_out |-> !pslverr_out)
        else $error("error outside answer");
    chk_read_width: assert property (pready_out && !pwrite_in |-> prdata_out[31:9] == 23'h00_0000)
        else $error("read bits above field");
    chk_break_pulse: assert property (break_req_out |=> !break_req_out)
        else $error("break longer than a cycle");
    chk_reset_comp: assert property (!$past(rst_b_in) |->
        {comp_a_ext_out, comp_a_high_out, comp_a_low_out} == 24'h00_FFFE)
        else $error("comparator A not at vector");
endmodule
bind tfc_trace_fifo_capture tfc_props i_props (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .break_req_out(break_req_out), .comp_a_ext_out(comp_a_ext_out),
    .comp_a_high_out(comp_a_high_out), .comp_a_low_out(comp_a_low_out));

// >>> verification/tfc_core_model.sv
`timescale 1ns/1ps
// ==========================================
// Core flow-change source
module tfc_core_model (
    input  wire        core_clk_in,
    output reg  [16:0] core_addr_out = 17'h0_0000,
    output reg  [1:0]  core_cof_out = 2'b00,
    output reg  [2:0]  trig_out = 3'b000
);
    // Quiet cycle, flagged cycle, then a scrambled address so no stale value lingers
    task emit(input [16:0] a, input [1:0] c, input [2:0] t);
        @(posedge core_clk_in);
        core_addr_out <= a;
        @(posedge core_clk_in);
        core_addr_out <= a + 17'h0_0001;
        core_cof_out <= c;
        trig_out <= t;
        @(posedge core_clk_in);
        core_addr_out <= ~a;
        core_cof_out <= 2'b00;
        trig_out <= 3'b000;
    endtask
endmodule

// >>> verification/tfc_trace_fifo_capture_tb_top.sv
`timescale 1ns/1ps
`include "tfc_map.vh"
// ==========================================
// Bench
module tfc_trace_fifo_capture_tb_top;
    reg         clk = 1'b0, rst_b = 1'b0, sys_rst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [7:0]  pwd = 8'h00;
    reg  [16:0] opc = 17'h0_0000;
    reg  [3:0]  tmode = 4'h0;
    reg  [16:0] expq [0:7];
    reg  [31:0] q;
    reg         e;
    wire [31:0] prd;
    wire        prdy, perr;
    wire [7:0]  cax, cah, cal;
    wire [16:0] caddr;
    wire [1:0]  cof;
    wire [2:0]  trg;
    integer     n_fail = 0, n_compared = 0, i, j;
    always #12.5 clk = ~clk;
    tfc_core_model i_core (.core_clk_in(clk), .core_addr_out(caddr), .core_cof_out(cof),
        .trig_out(trg));
    tfc_trace_fifo_capture i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1),
        .sys_reset_in(sys_rst), .core_addr_in(caddr), .opcode_addr_in(opc),
        .core_data_in(caddr[7:0]), .core_cof_in(cof), .irq_pending_in(trg[2]),
        .match_a_in(trg[0] | trg[1]), .match_b_in(trg[1]), .trig_addr_in(trg[0]),
        .trig_opcode_in(trg[1]), .trig_mode_in(tmode), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in({24'h00_0000, pwd}), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .break_req_out(), .comp_a_ext_out(cax),
        .comp_a_high_out(cah), .comp_a_low_out(cal));
    task cmp(input [31:0] got, input [31:0] x);
        n_compared = n_compared + 1;
        if (got !== x) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, x);
        end
    endtask
    // Request held until ready is seen; no fixed latency assumed
    task apb(input w, input [11:0] a, input [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input [11:0] a, input [7:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [11:0] a, input [8:0] x, input [8:0] m = 9'h1FF);
        apb(1'b0, a, 8'h00);
        cmp(q & {23'h7F_FFFF, m}, {23'h00_0000, x});
    endtask
    task go(input [16:0] a, input [1:0] c, input [2:0] t, input integer k);
        i_core.emit(a, c, t);
        if (k >= 0 && k < 8) expq[k] = c[1] ? a + 17'h0_0001 : a - 17'h0_0002;
    endtask
    task drain;
        for (i = 0; i < 8; i = i + 1) begin
            rd(`TFC_OFF_DHIGH, expq[i][16:8]);
            rd(`TFC_OFF_DLOW, {1'b0, expq[i][7:0]});
        end
    endtask
    task pulse;
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        go(17'h0_0300, 2'b10, 3'b000, -1);
        go(17'h1_2340, 2'b10, 3'b101, 0);
        for (j = 1; j < 9; j = j + 1) go(17'h1000 + j * 256, {j[0], ~j[0]}, 3'b000, j);
        rd(`TFC_OFF_COUNT, 9'h008);
        rd(`TFC_OFF_CTRL, 9'h080);
        rd(`TFC_OFF_STATUS, 9'h000, 9'h001);
        drain;
        rd(`TFC_OFF_COUNT, 9'h008);
        opc <= 17'h1_5A5C;
        apb(1'b0, `TFC_OFF_DLOW, 8'h00);
        rd(`TFC_OFF_DHIGH, 9'h15A);
        rd(`TFC_OFF_DLOW, 9'h05C);
        wr(`TFC_OFF_TRIG, 8'h80);
        wr(`TFC_OFF_CTRL, 8'hC0);
        rd(`TFC_OFF_STATUS, 9'h001, 9'h0E1);
        go(17'h0_0500, 2'b00, 3'b110, -1);
        rd(`TFC_OFF_CTRL, 9'h0C0);
        wr(`TFC_OFF_TRIG, 8'h00);
        for (j = 0; j < 10; j = j + 1) begin
            go(17'h2000 + j * 16, 2'b10, 3'b000, j - 3);
            if (j == 2) rd(`TFC_OFF_DLOW, 9'h001);
        end
        go(17'h0_3330, 2'b10, 3'b101, 7);
        go(17'h0_FFFC, 2'b10, 3'b000, 8);
        rd(`TFC_OFF_COUNT, 9'h008);
        rd(`TFC_OFF_CTRL, 9'h080);
        drain;
        wr(`TFC_OFF_CTRL, 8'hA0);
        pulse;
        rd(`TFC_OFF_CTRL, 9'h080);
        rd(`TFC_OFF_COUNT, 9'h008);
        wr(`TFC_OFF_TRIG, 8'h40);
        wr(`TFC_OFF_CMPA_LO, 8'h12);
        pulse;
        rd(`TFC_OFF_CTRL, 9'h0C0);
        rd(`TFC_OFF_TRIG, 9'h040);
        rd(`TFC_OFF_CMPA_LO, 9'h0FE);
        cmp({8'h00, cax, cah, cal}, 32'h0000_FFFE);
        rd(12'h100, 9'h000);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        // Event-only run: trigger arms capture, the B match stores the bus value
        tmode <= `TFC_MODE_EVB;
        go(17'h0_0440, 2'b00, 3'b001, -1);
        go(17'h0_0455, 2'b00, 3'b010, -1);
        wr(`TFC_OFF_CTRL, 8'h80);
        rd(`TFC_OFF_COUNT, 9'h001);
        rd(`TFC_OFF_DHIGH, 9'h000);
        rd(`TFC_OFF_DLOW, 9'h056);
        end_of_test;
    end
endmodule
